// *** nfc_host.v ***
// Host controller that drives a parallel NOR flash through its bus pins
// How it works
// R1: After the time-limit flag rises, poll the toggle line once more before failing.
// R2: Device raises time-limit flag on overtime or protected-sector program/erase.
// R3: Device raises program-voltage flag when protect supply is too low.
// R4: While programming, polling line inverts data (cfg 00) or reads zero (cfg 01).
// R5: Erase suspended, erasing sector read: poll and first toggle read one.
// R6: Program suspended, programming sector read: poll gives data or one.
// R7: Suspended, other sectors read ordinary data, completion pin high.
// R8: Command bytes sit on data lines 7..0; upper lines driven zero.
// R9: Command addresses use address lines 11..0; upper lines driven zero.
// R10: Second unlock cycle goes to AAA, which the device also takes as 2AA.
// R11: Six-cycle commands: unlock, 80, unlock, then 10, 30, 60 or A0.
// R12: Sector erase and lockdown final cycle uses any address in the sector.
// R13: Locked-down sectors refuse changes until reset or power cycle.
// R14: Identification exit uses F0, by three cycles or one write.
// R15: Block status bit 1 reads zero when user block is locked.
// R16: Configuration defaults to 00 until set to 00 or 01.
// R17: Dual program only at 12V; two addresses differ only in bit 0.
// R18: Unlock then A0 program, E0 dual, C0 protection program; X0 at 080 locks.
// R19: B0 suspends, 30 resumes, 98 at X55 queries, 90 identifies, D0 sets config.
// R20: Unmatched sequences leave the device in read state.
// R21: Completion pin is open drain, low while busy, shared by devices.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "nfc_map.vh"
module nfc_host #(
  parameter AW = 21,
  parameter DW = 16
) (
  input wire CLOCK,
  input wire SRST,
  input wire CEN,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  output reg [AW-1:0] FL_ADDR,
  input wire [DW-1:0] FL_DQ_IN,
  output reg [DW-1:0] FL_DQ_OUT,
  output reg FL_DQ_OE,
  output reg FL_CE_N,
  output reg FL_OE_N,
  output reg FL_WE_N,
  input wire FL_RDY
);
  localparam S_IDLE = 3'd0;
  localparam S_WSET = 3'd1;
  localparam S_WLOW = 3'd2;
  localparam S_WEND = 3'd3;
  localparam S_RLOW = 3'd4;
  localparam S_RCAP = 3'd5;
  localparam S_POLL = 3'd6;
  localparam integer PH_CYC = `NFC_PHASE_CYC;
  localparam [3:0] PH = PH_CYC[3:0];
  reg [2:0] st_ff;
  reg [3:0] ph_ff;
  reg [2:0] idx_ff;
  reg [2:0] len_ff;
  reg [3:0] op_ff;
  reg [AW-1:0] addr_ff;
  reg [31:0] data_ff;
  reg cfg_ff;
  reg busy_ff, fail_ff, vfail_ff, locked_ff, prev_tog_ff, recheck_ff;
  reg [DW-1:0] rdat_ff;
  reg [AW-1:0] cyc_a;
  reg [7:0] cyc_d;
  reg [2:0] seq_len;
  wire go = PSEL && PENABLE && PWRITE && PADDR == `NFC_OFS_CTRL && !busy_ff;
  wire [3:0] go_op = PWDATA[`NFC_CTRL_OP_MSB:`NFC_CTRL_OP_LSB];
  // Cycle count of each operation
  function [2:0] op_len;
    input [3:0] op;
    begin
      case (op)
        `NFC_OP_CHIP_ERASE, `NFC_OP_SECT_ERASE, `NFC_OP_SP_ENTER,
        `NFC_OP_LOCKDOWN: op_len = 3'd6; // [R11]
        `NFC_OP_DUAL: op_len = 3'd5; // [R17]
        `NFC_OP_PROGRAM, `NFC_OP_PR_PROG, `NFC_OP_PR_LOCK, `NFC_OP_SET_CFG: op_len = 3'd4;
        `NFC_OP_ID_ENTER, `NFC_OP_ID_EXIT: op_len = 3'd3;
        `NFC_OP_SP_PROG, `NFC_OP_SUSPEND, `NFC_OP_RESUME, `NFC_OP_QUERY: op_len = 3'd1;
        default: op_len = 3'd0;
      endcase
    end
  endfunction
  // Low address bits of a command cycle
  function [11:0] lo12;
    input [AW-1:0] a;
    begin
      lo12 = a[11:0];
    end
  endfunction
  always @* begin
    seq_len = op_len(op_ff);
    cyc_a = {AW{1'b0}}; // [R9]
    cyc_d = 8'h00;
    case (idx_ff)
      3'd0: begin
        cyc_a[11:0] = `NFC_ADR_UNLOCK1;
        cyc_d = `NFC_DAT_UNLOCK1;
      end
      3'd1, 3'd4: begin
        cyc_a[11:0] = `NFC_ADR_UNLOCK2; // [R10]
        cyc_d = `NFC_DAT_UNLOCK2;
      end
      3'd2: begin
        cyc_a[11:0] = `NFC_ADR_UNLOCK1;
        case (op_ff)
          `NFC_OP_PROGRAM: cyc_d = `NFC_DAT_PROGRAM; // [R18]
          `NFC_OP_DUAL: cyc_d = `NFC_DAT_DUAL; // [R18]
          `NFC_OP_PR_PROG, `NFC_OP_PR_LOCK: cyc_d = `NFC_DAT_PR_PROG; // [R18]
          `NFC_OP_ID_ENTER: cyc_d = `NFC_DAT_ID_ENTER; // [R19]
          `NFC_OP_ID_EXIT: cyc_d = `NFC_DAT_ID_EXIT; // [R14]
          `NFC_OP_SET_CFG: cyc_d = `NFC_DAT_SET_CFG; // [R19]
          default: cyc_d = `NFC_DAT_ERASE_SETUP; // [R11]
        endcase
      end
      3'd3: begin
        case (op_ff)
          `NFC_OP_PR_LOCK: begin
            cyc_a[11:0] = `NFC_ADR_PR_LOCK;
            cyc_d = `NFC_DAT_PR_LOCK; // [R18]
          end
          `NFC_OP_SET_CFG: cyc_d = {7'h00, cfg_ff}; // [R16]
          `NFC_OP_PROGRAM, `NFC_OP_DUAL, `NFC_OP_PR_PROG: begin
            cyc_a = addr_ff;
            cyc_d = data_ff[7:0];
          end
          default: begin
            cyc_a[11:0] = `NFC_ADR_UNLOCK1;
            cyc_d = `NFC_DAT_UNLOCK1;
          end
        endcase
      end
      3'd5: begin
        if (op_ff == `NFC_OP_CHIP_ERASE) begin
          cyc_a[11:0] = `NFC_ADR_UNLOCK1;
          cyc_d = `NFC_DAT_CHIP_ERASE; // [R11]
        end else if (op_ff == `NFC_OP_SP_ENTER) begin
          cyc_a[11:0] = `NFC_ADR_UNLOCK1;
          cyc_d = `NFC_DAT_PROGRAM;
        end else begin
          cyc_a = addr_ff; // [R12]
          cyc_d = op_ff == `NFC_OP_LOCKDOWN ? `NFC_DAT_LOCKDOWN : `NFC_DAT_SECT_ERASE;
        end
      end
      default: begin
        cyc_a = addr_ff;
        cyc_d = data_ff[7:0];
      end
    endcase
    if (op_ff == `NFC_OP_DUAL && idx_ff == 3'd4) begin
      cyc_a = {addr_ff[AW-1:1], ~addr_ff[0]}; // [R17]
      cyc_d = data_ff[23:16];
    end
    if (seq_len == 3'd1) begin
      case (op_ff)
        `NFC_OP_SUSPEND: cyc_d = `NFC_DAT_SUSPEND; // [R19]
        `NFC_OP_RESUME: cyc_d = `NFC_DAT_RESUME; // [R19]
        `NFC_OP_QUERY: begin
          cyc_a[11:0] = `NFC_ADR_QUERY;
          cyc_d = `NFC_DAT_QUERY; // [R19]
        end
        default: begin
          cyc_a = addr_ff;
          cyc_d = data_ff[7:0];
        end
      endcase
    end
  end
  wire polls = op_ff == `NFC_OP_CHIP_ERASE || op_ff == `NFC_OP_SECT_ERASE ||
    op_ff == `NFC_OP_PROGRAM || op_ff == `NFC_OP_DUAL || op_ff == `NFC_OP_SP_PROG ||
    op_ff == `NFC_OP_PR_PROG || op_ff == `NFC_OP_LOCKDOWN;
  wire wide_data = op_ff == `NFC_OP_PROGRAM || op_ff == `NFC_OP_SP_PROG ||
    op_ff == `NFC_OP_PR_PROG || op_ff == `NFC_OP_DUAL;
  always @(posedge CLOCK) begin
    if (SRST) begin
      st_ff <= S_IDLE;
      ph_ff <= 4'h0;
      idx_ff <= 3'd0;
      len_ff <= 3'd0;
      op_ff <= 4'h0;
      addr_ff <= {AW{1'b0}};
      data_ff <= 32'h00000000;
      cfg_ff <= 1'b0; // [R16]
      busy_ff <= 1'b0;
      fail_ff <= 1'b0;
      vfail_ff <= 1'b0;
      locked_ff <= 1'b0;
      prev_tog_ff <= 1'b0;
      recheck_ff <= 1'b0;
      rdat_ff <= {DW{1'b0}};
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      FL_ADDR <= {AW{1'b0}};
      FL_DQ_OUT <= {DW{1'b0}};
      FL_DQ_OE <= 1'b0;
      FL_CE_N <= 1'b1;
      FL_OE_N <= 1'b1;
      FL_WE_N <= 1'b1;
    end else if (CEN) begin
      PREADY <= PSEL && !PREADY;
      PSLVERR <= 1'b0;
      if (PSEL && !PREADY) begin
        if (PWRITE) begin
          case (PADDR)
            `NFC_OFS_ADDR, `NFC_OFS_DATA, `NFC_OFS_CTRL: ;
            default: PSLVERR <= 1'b1;
          endcase
        end else begin
          case (PADDR)
            `NFC_OFS_CTRL: PRDATA <= {23'h000000, cfg_ff, op_ff, 4'h0};
            `NFC_OFS_ADDR: PRDATA <= {{(32-AW){1'b0}}, addr_ff};
            `NFC_OFS_DATA: PRDATA <= data_ff;
            `NFC_OFS_STAT: PRDATA <= {27'h0000000, locked_ff, FL_RDY, vfail_ff, fail_ff, busy_ff};
            `NFC_OFS_RDAT: PRDATA <= {{(32-DW){1'b0}}, rdat_ff};
            default: begin
              PRDATA <= 32'h00000000;
              PSLVERR <= 1'b1;
            end
          endcase
        end
      end
      // Writes land only at the completing access edge
      if (PSEL && PENABLE && PREADY && PWRITE) begin
        if (PADDR == `NFC_OFS_ADDR) addr_ff <= PWDATA[AW-1:0];
        if (PADDR == `NFC_OFS_DATA) data_ff <= PWDATA;
      end
      if (go && PREADY && PWDATA[`NFC_CTRL_GO]) begin
        op_ff <= go_op;
        if (go_op == `NFC_OP_SET_CFG) cfg_ff <= PWDATA[`NFC_CTRL_CFG]; // [R16]
        busy_ff <= 1'b1;
        fail_ff <= 1'b0;
        vfail_ff <= 1'b0;
        recheck_ff <= 1'b0;
        idx_ff <= 3'd0;
        ph_ff <= 4'h0;
        st_ff <= op_len(go_op) == 3'd0 ? S_RLOW : S_WSET;
      end
      case (st_ff)
        S_IDLE: ;
        S_WSET: begin
          FL_ADDR <= cyc_a;
          FL_DQ_OUT <= {{(DW-8){1'b0}}, cyc_d}; // [R8]
          if (wide_data && (idx_ff + 3'd1 == seq_len || (op_ff == `NFC_OP_DUAL && idx_ff == 3'd3)))
            FL_DQ_OUT <= op_ff == `NFC_OP_DUAL && idx_ff == 3'd4 ?
              data_ff[31:32-DW] : data_ff[DW-1:0];
          FL_DQ_OE <= 1'b1;
          FL_CE_N <= 1'b0;
          st_ff <= S_WLOW;
        end
        S_WLOW: begin
          FL_WE_N <= 1'b0;
          ph_ff <= ph_ff + 4'h1;
          if (ph_ff == PH) begin
            ph_ff <= 4'h0;
            FL_WE_N <= 1'b1;
            st_ff <= S_WEND;
          end
        end
        S_WEND: begin
          FL_DQ_OE <= 1'b0;
          FL_CE_N <= 1'b1;
          if (idx_ff + 3'd1 == seq_len) begin
            idx_ff <= 3'd0;
            st_ff <= polls ? S_RLOW : S_IDLE;
            busy_ff <= polls || op_ff == `NFC_OP_ID_ENTER;
            if (op_ff == `NFC_OP_ID_ENTER) st_ff <= S_RLOW; // [R15]
          end else begin
            idx_ff <= idx_ff + 3'd1;
            st_ff <= S_WSET;
          end
        end
        S_RLOW: begin
          FL_ADDR <= op_ff == `NFC_OP_ID_ENTER ? {{(AW-12){1'b0}}, `NFC_ADR_PR_LOCK} : addr_ff;
          FL_CE_N <= 1'b0;
          FL_OE_N <= 1'b0;
          ph_ff <= ph_ff + 4'h1;
          if (ph_ff == PH) begin
            ph_ff <= 4'h0;
            st_ff <= S_RCAP;
          end
        end
        S_RCAP: begin
          FL_CE_N <= 1'b1;
          FL_OE_N <= 1'b1;
          rdat_ff <= FL_DQ_IN;
          // Toggle bit of the read before this one
          prev_tog_ff <= rdat_ff[6];
          if (op_ff == `NFC_OP_ID_ENTER) locked_ff <= !FL_DQ_IN[1]; // [R15]
          st_ff <= polls ? S_POLL : S_IDLE;
          busy_ff <= polls;
          if (polls && idx_ff == 3'd0) begin
            idx_ff <= 3'd1;
            st_ff <= S_RLOW;
          end
        end
        S_POLL: begin
          // Toggle stopped means done; the time-limit flag is only trusted after a recheck, the voltage flag at once
          if (rdat_ff[6] == prev_tog_ff) begin
            st_ff <= S_IDLE;
            busy_ff <= 1'b0;
            idx_ff <= 3'd0;
          end else if (rdat_ff[3]) begin
            vfail_ff <= 1'b1; // [R3]
            busy_ff <= 1'b0;
            st_ff <= S_IDLE;
            idx_ff <= 3'd0;
          end else if (rdat_ff[5] && recheck_ff) begin
            fail_ff <= 1'b1; // [R1] [R2] [R13]
            busy_ff <= 1'b0;
            st_ff <= S_IDLE;
            idx_ff <= 3'd0;
          end else begin
            recheck_ff <= rdat_ff[5]; // [R1]
            st_ff <= S_RLOW;
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end
endmodule // nfc_host
`default_nettype wire

// *** nfc_map.vh ***
// Register offsets, command codes and timing counts for the flash host controller
`ifndef NFC_MAP_VH
`define NFC_MAP_VH
`define NFC_OFS_CTRL 12'h000
`define NFC_OFS_ADDR 12'h004
`define NFC_OFS_DATA 12'h008
`define NFC_OFS_STAT 12'h00c
`define NFC_OFS_RDAT 12'h010
`define NFC_CTRL_GO 0
`define NFC_CTRL_OP_LSB 4
`define NFC_CTRL_OP_MSB 7
`define NFC_CTRL_CFG 8
`define NFC_STAT_BUSY 0
`define NFC_STAT_FAIL 1
`define NFC_STAT_VFAIL 2
`define NFC_STAT_RDY 3
`define NFC_STAT_LOCKED 4
`define NFC_OP_READ 4'h0
`define NFC_OP_CHIP_ERASE 4'h1
`define NFC_OP_SECT_ERASE 4'h2
`define NFC_OP_PROGRAM 4'h3
`define NFC_OP_DUAL 4'h4
`define NFC_OP_SP_ENTER 4'h5
`define NFC_OP_SP_PROG 4'h6
`define NFC_OP_LOCKDOWN 4'h7
`define NFC_OP_SUSPEND 4'h8
`define NFC_OP_RESUME 4'h9
`define NFC_OP_ID_ENTER 4'ha
`define NFC_OP_ID_EXIT 4'hb
`define NFC_OP_PR_PROG 4'hc
`define NFC_OP_PR_LOCK 4'hd
`define NFC_OP_SET_CFG 4'he
`define NFC_OP_QUERY 4'hf
`define NFC_ADR_UNLOCK1 12'h555
`define NFC_ADR_UNLOCK2 12'haaa
`define NFC_ADR_QUERY 12'h055
`define NFC_ADR_PR_LOCK 12'h080
`define NFC_DAT_UNLOCK1 8'haa
`define NFC_DAT_UNLOCK2 8'h55
`define NFC_DAT_ERASE_SETUP 8'h80
`define NFC_DAT_CHIP_ERASE 8'h10
`define NFC_DAT_SECT_ERASE 8'h30
`define NFC_DAT_LOCKDOWN 8'h60
`define NFC_DAT_PROGRAM 8'ha0
`define NFC_DAT_DUAL 8'he0
`define NFC_DAT_PR_PROG 8'hc0
`define NFC_DAT_ID_ENTER 8'h90
`define NFC_DAT_ID_EXIT 8'hf0
`define NFC_DAT_SET_CFG 8'hd0
`define NFC_DAT_SUSPEND 8'hb0
`define NFC_DAT_RESUME 8'h30
`define NFC_DAT_QUERY 8'h98
`define NFC_DAT_PR_LOCK 8'h00
`define NFC_BUS_NS 100
`define NFC_CLK_NS 100
`define NFC_PHASE_CYC ((`NFC_BUS_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`endif

// *** nfc_host_assertions.sv ***
// Checker for the flash host APB answer and flash strobe timing
`timescale 1ns/100ps
`default_nettype none
module nfc_chk #(
  parameter AW = 21,
  parameter DW = 16
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [AW-1:0] FL_ADDR,
  input wire logic [DW-1:0] FL_DQ_OUT,
  input wire logic FL_DQ_OE,
  input wire logic FL_CE_N,
  input wire logic FL_OE_N,
  input wire logic FL_WE_N
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SRST);
  property p_ans;
    PSEL && !PENABLE |=> PREADY;
  endproperty
  a_ans: assert property (p_ans) else $error("no zero-wait answer");
  property p_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready not a pulse");
  property p_err;
    PSLVERR |-> PREADY && PSEL && PENABLE;
  endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_we_len;
    $fell(FL_WE_N) |=> FL_WE_N;
  endproperty
  a_we_len: assert property (p_we_len) else $error("write strobe not one cycle");
  property p_setup;
    $fell(FL_WE_N) |-> $past(FL_DQ_OE) && !$past(FL_CE_N);
  endproperty
  a_setup: assert property (p_setup) else $error("no setup before write");
  property p_hold;
    !FL_WE_N |-> $stable(FL_ADDR) && $stable(FL_DQ_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("bus moved under write");
  property p_unlock1;
    !FL_WE_N && FL_DQ_OUT == 16'h00aa |-> FL_ADDR == 21'h000555;
  endproperty
  a_unlock1: assert property (p_unlock1) else $error("first unlock address");
  property p_unlock2;
    !FL_WE_N && FL_DQ_OUT[7:0] == 8'h55 |-> FL_ADDR[11:0] == 12'haaa && FL_DQ_OUT[15:8] == 8'h00;
  endproperty
  a_unlock2: assert property (p_unlock2) else $error("second unlock cycle");
  property p_read;
    !FL_OE_N |-> FL_WE_N && !FL_DQ_OE && !FL_CE_N;
  endproperty
  a_read: assert property (p_read) else $error("read with bus driven");
  c_err: cover property (PSLVERR);
  c_write: cover property ($fell(FL_WE_N));
  c_read: cover property ($fell(FL_OE_N));
endmodule // nfc_chk
bind nfc_host nfc_chk #(.AW(AW), .DW(DW)) u_chk (.CLOCK, .SRST, .PSEL, .PENABLE, .PREADY,
  .PSLVERR, .FL_ADDR, .FL_DQ_OUT, .FL_DQ_OE, .FL_CE_N, .FL_OE_N, .FL_WE_N);
`default_nettype wire

// *** nfc_flash_model.sv ***
// Behavioural flash: unlock plus program decode, toggle polling, busy pin
`timescale 1ns/100ps
`default_nettype none
module nfc_flash_model (
  input wire logic [20:0] addr,
  input wire logic [15:0] dq_in,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output logic [15:0] dq_out,
  output logic pull_low
);
  // User block of the protection register starts locked
  localparam logic BLK_LOCKED = 1'b1;
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0000;
  logic [15:0] wdat = 16'h0000;
  logic [20:0] padr = 21'h000000;
  logic [1:0] seq = 2'h0;
  logic tog = 1'b0;
  logic tog2 = 1'b0;
  logic prot = 1'b0;
  logic susp = 1'b0;
  logic idm = 1'b0;
  int busy = 0;
  assign pull_low = busy != 0 && !susp;
  assign dq_out = (!oe_n && !ce_n) ? last : ~last;
  always @(posedge we_n) if (!ce_n) begin
    idm = 1'b0;
    if (seq == 2'h3) begin
      wdat = dq_in;
      padr = addr;
      prot = addr[20];
      if (!prot) mem[addr[7:0]] = dq_in;
      busy = 3;
      seq = 2'h0;
    end else if (dq_in[7:0] == 8'hb0 && busy != 0) susp = 1'b1;
    else if (dq_in[7:0] == 8'h30 && susp) susp = 1'b0;
    else if (dq_in[7:0] == 8'haa && addr[10:0] == 11'h555) seq = 2'h1;
    else if (seq == 2'h1 && dq_in[7:0] == 8'h55 && addr[10:0] == 11'h2aa) seq = 2'h2;
    else if (seq == 2'h2 && dq_in[7:0] == 8'h90 && addr[10:0] == 11'h555) begin
      idm = 1'b1;
      seq = 2'h0;
    end else if (seq == 2'h2 && dq_in[7:0] == 8'ha0 && addr[10:0] == 11'h555) seq = 2'h3;
    else seq = 2'h0;
  end
  // Protected target keeps toggling with the time-limit flag up
  always @(negedge oe_n) if (!ce_n) begin
    if (idm && addr[7:0] == 8'h80) last = {14'h0000, ~BLK_LOCKED, 1'b0};
    else if (susp && addr == padr) begin
      tog2 = ~tog2;
      last = {8'h00, wdat[7], 1'b1, 3'b000, tog2, 2'b00};
    end else if (susp || busy == 0) last = mem[addr[7:0]];
    else begin
      tog = ~tog;
      last = {8'h00, ~wdat[7], tog, prot, 5'h04};
      if (!prot) busy = busy - 1;
    end
  end
endmodule // nfc_flash_model
`default_nettype wire

// *** tb.sv ***
// Testbench: APB sequences against the flash model
`timescale 1ns/100ps
`default_nettype none
`include "nfc_map.vh"
module tb;
  logic CLOCK = 0, SRST = 1, CEN = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, r;
  logic PREADY, PSLVERR, FL_DQ_OE, FL_CE_N, FL_OE_N, FL_WE_N, FL_RDY, pull_low, err;
  logic [20:0] FL_ADDR;
  logic [15:0] FL_DQ_IN, FL_DQ_OUT, m_dq;
  int failures = 0, cmp_count = 0, cyc = 0;
  always #50 CLOCK = ~CLOCK;
  assign FL_RDY = pull_low ? 1'b0 : 1'b1;
  assign FL_DQ_IN = FL_DQ_OE ? FL_DQ_OUT : m_dq;
  nfc_host dut (.CLOCK, .SRST, .CEN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .FL_ADDR, .FL_DQ_IN, .FL_DQ_OUT, .FL_DQ_OE, .FL_CE_N, .FL_OE_N,
    .FL_WE_N, .FL_RDY);
  nfc_flash_model u_flash (.addr(FL_ADDR), .dq_in(FL_DQ_IN), .ce_n(FL_CE_N), .oe_n(FL_OE_N),
    .we_n(FL_WE_N), .dq_out(m_dq), .pull_low);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLOCK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    r = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    if (n == 50) failures++;
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 300; n++) begin
      apb(0, `NFC_OFS_STAT, 0);
      if (r[`NFC_STAT_BUSY] === 1'b0) break;
    end
    if (n == 300) failures++;
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge CLOCK);
    SRST <= 0;
    apb(0, `NFC_OFS_STAT, 0);
    chk(r, 32'h8);
    apb(0, 12'h020, 0);
    chk({err, r[30:0]}, 32'h80000000);
    apb(1, `NFC_OFS_ADDR, 32'h123);
    apb(1, `NFC_OFS_DATA, 32'hbeef);
    apb(1, `NFC_OFS_CTRL, 32'h31);
    apb(0, `NFC_OFS_STAT, 0);
    chk({31'h0, r[0]}, 32'h1);
    wait_idle;
    chk(r, 32'h8);
    chk({16'h0, u_flash.mem[8'h23]}, 32'hbeef);
    apb(1, `NFC_OFS_CTRL, 32'h01);
    wait_idle;
    apb(0, `NFC_OFS_RDAT, 0);
    chk(r, 32'hbeef);
    apb(1, `NFC_OFS_ADDR, 32'h100123);
    apb(1, `NFC_OFS_CTRL, 32'h31);
    wait_idle;
    chk(r, 32'h2);
    chk({16'h0, u_flash.mem[8'h23]}, 32'hbeef);
    apb(1, `NFC_OFS_CTRL, 32'h81);
    wait_idle;
    chk(r, 32'h8);
    apb(1, `NFC_OFS_CTRL, 32'h01);
    wait_idle;
    apb(0, `NFC_OFS_RDAT, 0);
    chk(r, 32'hc4);
    apb(1, `NFC_OFS_ADDR, 32'h123);
    apb(1, `NFC_OFS_CTRL, 32'h01);
    wait_idle;
    apb(0, `NFC_OFS_RDAT, 0);
    chk(r, 32'hbeef);
    apb(1, `NFC_OFS_CTRL, 32'h91);
    wait_idle;
    chk(r, 32'h0);
    apb(1, `NFC_OFS_CTRL, 32'ha1);
    wait_idle;
    chk(r, 32'h10);
    apb(1, `NFC_OFS_CTRL, 32'hb1);
    wait_idle;
    chk({31'h0, u_flash.idm}, 32'h0);
    give_verdict;
  end
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      give_verdict;
    end
  end
endmodule // tb
`default_nettype wire
